/* hdl/lcm_pkg.sv */
// Package with constants and types for the laser control-mode logic.
package lcm_pkg;
  localparam int unsigned LCM_CLK_HZ = 10000000;
  localparam int unsigned LCM_AIM_DELAY_MS = 10;
  // Least delay in whole cycles; the cycles per millisecond round down.
  localparam int unsigned LCM_AIM_DELAY_CYC = (LCM_CLK_HZ / 1000) * LCM_AIM_DELAY_MS;
  localparam int unsigned LCM_PROG_W = 7;
  localparam int unsigned LCM_PCT_W = 8;
  localparam logic [7:0] LCM_PCT_MAX = 8'h64;
  localparam logic [7:0] LCM_PCT_RST = 8'h00;
  // Register indices on the plain register port.
  localparam logic [3:0] LCM_REG_CFG = 4'h0;
  localparam logic [3:0] LCM_REG_CMD = 4'h1;
  localparam logic [3:0] LCM_REG_PCT = 4'h2;
  localparam logic [3:0] LCM_REG_STAT = 4'h3;
  localparam logic [3:0] LCM_REG_NV = 4'h4;
  // CFG bit positions.
  localparam int unsigned LCM_CFG_AD = 0;
  localparam int unsigned LCM_CFG_EXT = 1;
  localparam int unsigned LCM_CFG_PROG_LSB = 8;
  // CMD bit positions (write one to act).
  localparam int unsigned LCM_CMD_EMISSION_START_CMD = 0;
  localparam int unsigned LCM_CMD_EMISSION_STOP_CMD = 1;
  localparam int unsigned LCM_CMD_ABN = 2;
  localparam int unsigned LCM_CMD_ABF = 3;
  localparam int unsigned LCM_CMD_PWRON = 4;
  localparam int unsigned LCM_CMD_PWROFF = 5;
  localparam int unsigned LCM_CMD_ABORTCLR = 6;
  localparam int unsigned LCM_CMD_BAD = 7;

  typedef struct packed {
    logic host_request;
    logic emission_request;
    logic internal_select;
    logic aiming_beam;
    logic analog_select;
    logic main_power_request;
    logic gate_diff_pos;
    logic gate_diff_neg;
    logic [LCM_PROG_W-1:0] program_select;
  } lcm_pins_t;

  typedef struct packed {
    logic emission_en;
    logic power_from_analog;
    logic program_mode;
    logic program_run;
    logic aim_on;
    logic ready;
    logic green_lamp;
    logic main_power;
  } lcm_outs_t;

  typedef enum logic [2:0] {
    LCM_P_IDLE = 3'b001,
    LCM_P_RUN = 3'b010,
    LCM_P_DONE = 3'b100
  } lcm_prog_st_t;
endpackage : lcm_pkg

/* hdl/lcm_mode_ctrl.sv */
// Control-mode selection logic: power source, emission gating, aiming beam and program runs.
//
// Behaviour
// - Local options restore from and save to non-volatile storage port.
// - Local key: analog mode picks analog power, else command percentage.
// - Local key: external control gates emission from differential gate pair.
// - Local key: aiming beam switches only from aiming on/off commands.
// - Ready and green lamp drop while aiming beam on, return when off.
// - Local key: nonzero stored program number means programming mode.
// - Programming, internal control: start command runs program, stop ends it.
// - Programming, external control: gate rising edge starts, falling edge ends.
// - Gate falling before program end aborts and flags abnormal termination.
// - Pin key: host request and analog select high choose analog power.
// - Pin key: internal select picks commands, else request pin with gate.
// - Pin key: internal select picks commands, else aiming beam pin.
// - Aiming beam changes take effect after at least 10 ms.
// - Pin key: nonzero program bus means programming, request pin gates.
// - Pin key: main power request input switches main power on.
// - Unrecognised command gets a command error reply flag; here the flag just copies CMD bit 7 (LCM_CMD_BAD) of each command write.
// - Diode current percentages above 100 are clamped to 100.
//
// Added by the designer: the address-and-strobe port and the register addresses.
module lcm_mode_ctrl
  import lcm_pkg::*;
#(
  parameter int unsigned AIM_DELAY_CYC = LCM_AIM_DELAY_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic pin_strapped_key_position,
  input wire lcm_pins_t pins,
  input wire logic program_done,
  input wire logic [15:0] nv_cfg,
  input wire logic nv_valid,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic [15:0] nv_save_data,
  output logic nv_save,
  output lcm_outs_t outs,
  output logic [LCM_PCT_W-1:0] diode_current_pct,
  output logic [LCM_PROG_W-1:0] active_program
);
  localparam int unsigned SYNC_W = $bits(lcm_pins_t) + 2;

  logic [SYNC_W-1:0] s1_r;
  logic [SYNC_W-1:0] s2_r;
  lcm_pins_t p;
  logic key_pin;
  logic prog_done_s;
  logic nv_loaded_r;
  logic cfg_ad_r;
  logic cfg_ext_r;
  logic [LCM_PROG_W-1:0] cfg_prog_r;
  logic [LCM_PCT_W-1:0] pct_r;
  logic emit_cmd_r;
  logic aim_cmd_r;
  logic aim_on_r;
  logic [23:0] aim_cnt_r;
  logic pwr_r;
  logic abort_r;
  logic cmd_err_r;
  logic gate_prev_r;
  lcm_prog_st_t pst_r;
  logic key_prev_r;
  logic wr_cfg;
  logic wr_cmd;
  logic gate_diff;
  logic gate_src;
  logic aim_want;
  logic prog_mode;
  logic ext_ctrl;
  logic analog_pwr;
  logic emit_req;
  logic run_start;
  logic run_stop;
  logic ready;

  // The aiming delay counter must be able to reach the last count before the switch.
  if (AIM_DELAY_CYC < 1 || AIM_DELAY_CYC > (2 ** $bits(aim_cnt_r))) begin : g_bad_aim_delay
    $error("AIM_DELAY_CYC must lie between one and the aiming counter range");
  end

  // Pins and the asynchronous done line pass two flip-flops; only s2_r is read.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_r <= '0;
      s2_r <= '0;
    end else begin
      s1_r <= {pin_strapped_key_position, program_done, pins};
      s2_r <= s1_r;
    end
  end
  assign key_pin = s2_r[SYNC_W-1];
  assign prog_done_s = s2_r[SYNC_W-2];
  assign p = s2_r[$bits(lcm_pins_t)-1:0];

  assign wr_cfg = reg_wr && (reg_addr == LCM_REG_CFG);
  assign wr_cmd = reg_wr && (reg_addr == LCM_REG_CMD);
  assign gate_diff = p.gate_diff_pos && !p.gate_diff_neg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      nv_loaded_r <= 1'b0;
      cfg_ad_r <= 1'b0;
      cfg_ext_r <= 1'b0;
      cfg_prog_r <= '0;
      nv_save <= 1'b0;
      nv_save_data <= '0;
    end else begin
      nv_save <= 1'b0;
      if (!nv_loaded_r && nv_valid) begin
        nv_loaded_r <= 1'b1;
        cfg_ad_r <= nv_cfg[LCM_CFG_AD];
        cfg_ext_r <= nv_cfg[LCM_CFG_EXT];
        cfg_prog_r <= nv_cfg[LCM_CFG_PROG_LSB +: LCM_PROG_W];
      end else if (wr_cfg && !key_pin) begin
        cfg_ad_r <= reg_wdata[LCM_CFG_AD];
        cfg_ext_r <= reg_wdata[LCM_CFG_EXT];
        cfg_prog_r <= reg_wdata[LCM_CFG_PROG_LSB +: LCM_PROG_W];
        nv_save <= 1'b1;
        nv_save_data <= reg_wdata;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pct_r <= LCM_PCT_RST;
    end else if (reg_wr && reg_addr == LCM_REG_PCT) begin
      pct_r <= (reg_wdata[LCM_PCT_W-1:0] > LCM_PCT_MAX) ? LCM_PCT_MAX : reg_wdata[LCM_PCT_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      key_prev_r <= 1'b0;
    end else begin
      key_prev_r <= key_pin;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aim_cmd_r <= 1'b0;
    end else if (wr_cmd && reg_wdata[LCM_CMD_ABF]) begin
      aim_cmd_r <= 1'b0;
    end else if (wr_cmd && reg_wdata[LCM_CMD_ABN]) begin
      aim_cmd_r <= 1'b1;
    end
  end

  assign aim_want = (key_pin && p.host_request && !p.internal_select) ? p.aiming_beam : aim_cmd_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aim_on_r <= 1'b0;
      aim_cnt_r <= '0;
    end else if (aim_want == aim_on_r) begin
      aim_cnt_r <= '0;
    end else if (aim_cnt_r >= 24'(AIM_DELAY_CYC - 1)) begin
      aim_on_r <= aim_want;
      aim_cnt_r <= '0;
    end else begin
      aim_cnt_r <= aim_cnt_r + 24'h000001;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pwr_r <= 1'b0;
    end else if (wr_cmd && reg_wdata[LCM_CMD_PWROFF]) begin
      pwr_r <= 1'b0;
    end else if ((wr_cmd && reg_wdata[LCM_CMD_PWRON]) || (key_pin && p.main_power_request)) begin
      pwr_r <= 1'b1;
    end
  end

  assign ready = pwr_r && !aim_on_r;

  assign prog_mode = key_pin ? (p.host_request && (p.program_select != '0)) : (cfg_prog_r != '0);
  assign analog_pwr = key_pin ? (p.host_request && p.analog_select) : cfg_ad_r;
  assign ext_ctrl = key_pin ? (p.host_request && !p.internal_select) : cfg_ext_r;
  assign gate_src = key_pin ? (p.emission_request && gate_diff) : gate_diff;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      emit_cmd_r <= 1'b0;
    end else if ((wr_cmd && reg_wdata[LCM_CMD_EMISSION_STOP_CMD]) || !ready || key_pin != key_prev_r) begin
      emit_cmd_r <= 1'b0;
    end else if (wr_cmd && reg_wdata[LCM_CMD_EMISSION_START_CMD]) begin
      emit_cmd_r <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gate_prev_r <= 1'b0;
    end else begin
      gate_prev_r <= key_pin ? p.emission_request : gate_diff;
    end
  end

  always_comb begin
    run_start = 1'b0;
    run_stop = 1'b0;
    if (key_pin) begin
      run_start = p.emission_request && !gate_prev_r;
      run_stop = !p.emission_request;
    end else if (ext_ctrl) begin
      run_start = gate_diff && !gate_prev_r;
      run_stop = !gate_diff;
    end else begin
      run_start = wr_cmd && reg_wdata[LCM_CMD_EMISSION_START_CMD];
      run_stop = wr_cmd && reg_wdata[LCM_CMD_EMISSION_STOP_CMD];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pst_r <= LCM_P_IDLE;
    end else if (!prog_mode || !ready) begin
      pst_r <= LCM_P_IDLE;
    end else begin
      case (pst_r)
        LCM_P_IDLE: begin
          if (run_start) begin
            pst_r <= LCM_P_RUN;
          end
        end
        LCM_P_RUN: begin
          if (run_stop) begin
            pst_r <= LCM_P_IDLE;
          end else if (prog_done_s) begin
            pst_r <= LCM_P_DONE;
          end
        end
        LCM_P_DONE: begin
          if (run_stop) begin
            pst_r <= LCM_P_IDLE;
          end
        end
        default: pst_r <= LCM_P_IDLE;
      endcase
    end
  end

  // abort flag; a new abort wins over a software clear.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      abort_r <= 1'b0;
    end else if (pst_r == LCM_P_RUN && prog_mode && ext_ctrl && run_stop && !prog_done_s) begin
      abort_r <= 1'b1;
    end else if (wr_cmd && reg_wdata[LCM_CMD_ABORTCLR]) begin
      abort_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_err_r <= 1'b0;
    end else if (wr_cmd) begin
      cmd_err_r <= reg_wdata[LCM_CMD_BAD];
    end
  end

  assign emit_req = prog_mode ? (pst_r == LCM_P_RUN) : (ext_ctrl ? gate_src : emit_cmd_r);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      outs <= '0;
      diode_current_pct <= '0;
      active_program <= '0;
    end else begin
      outs.emission_en <= emit_req && ready;
      outs.power_from_analog <= analog_pwr;
      outs.program_mode <= prog_mode;
      outs.program_run <= (pst_r == LCM_P_RUN) && ready;
      outs.aim_on <= aim_on_r;
      outs.ready <= ready;
      outs.green_lamp <= ready;
      outs.main_power <= pwr_r;
      diode_current_pct <= pct_r;
      active_program <= key_pin ? p.program_select : cfg_prog_r;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        LCM_REG_CFG: reg_rdata <= {1'b0, cfg_prog_r, 6'h00, cfg_ext_r, cfg_ad_r};
        LCM_REG_PCT: reg_rdata <= {8'h00, pct_r};
        LCM_REG_STAT: reg_rdata <= {5'h00, pst_r, cmd_err_r, abort_r, key_pin, prog_mode, aim_on_r, ready, pwr_r,
                                    emit_req && ready};
        LCM_REG_NV: reg_rdata <= nv_save_data;
        default: reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end
endmodule : lcm_mode_ctrl

/* verification/lcm_mode_ctrl_properties.sv */
// Port-level checks for the laser control-mode block.
module lcm_mode_ctrl_properties
  import lcm_pkg::*;
#(
  parameter int unsigned AIM_DELAY_CYC = LCM_AIM_DELAY_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic pin_strapped_key_position,
  input wire lcm_pins_t pins,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic nv_save,
  input wire lcm_outs_t outs,
  input wire logic [LCM_PCT_W-1:0] diode_current_pct,
  input wire logic [LCM_PROG_W-1:0] active_program
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  logic cmd_wr;
  assign cmd_wr = reg_wr && reg_addr == LCM_REG_CMD && !pin_strapped_key_position;
  // The percentage register lands one edge after the write and reaches the output one edge later.
  property pct_follow;
    (reg_wr && reg_addr == LCM_REG_PCT) |-> ##2
      diode_current_pct == (($past(reg_wdata[7:0], 2) > LCM_PCT_MAX) ? LCM_PCT_MAX : $past(reg_wdata[7:0], 2));
  endproperty
  chk_ready_cause: assert property (outs.ready |-> outs.main_power && !outs.aim_on)
    else $error("ready without power or with aim beam on");
  chk_lamp_aim: assert property (outs.aim_on |-> !outs.green_lamp)
    else $error("green lamp lit with aim beam on");
  chk_emit_gate: assert property (outs.emission_en |-> outs.ready && outs.main_power)
    else $error("emission while not ready");
  chk_pct_bound: assert property (diode_current_pct <= LCM_PCT_MAX)
    else $error("current percentage above limit");
  chk_pct_clamp: assert property (pct_follow)
    else $error("current percentage not taken or not clamped");
  chk_nv_store: assert property (reg_wr && reg_addr == LCM_REG_CFG && !pin_strapped_key_position |-> ##[1:3] nv_save)
    else $error("local settings not saved");
  chk_aim_wait: assert property (cmd_wr && reg_wdata[LCM_CMD_ABN] && !outs.aim_on |=> !outs.aim_on [*3])
    else $error("aim beam switched too soon");
  chk_prog_nonzero: assert property (outs.program_mode |-> active_program != '0)
    else $error("programming mode with program zero");
  chk_rem_analog: assert property ((pin_strapped_key_position && pins.host_request && pins.analog_select) [*5]
    |=> outs.power_from_analog)
    else $error("analog power not selected by pins");
  cov_run: cover property ($rose(outs.program_run));
  cov_aim: cover property ($rose(outs.aim_on));
  cov_emit: cover property ($rose(outs.emission_en));
endmodule : lcm_mode_ctrl_properties

bind lcm_mode_ctrl lcm_mode_ctrl_properties #(.AIM_DELAY_CYC(AIM_DELAY_CYC)) u_props (
  .clk, .rst_b, .pin_strapped_key_position, .pins, .reg_addr, .reg_wdata, .reg_wr, .nv_save, .outs,
  .diode_current_pct, .active_program
);

/* verification/lcm_board_model.sv */
// Control board model driving the connector pins.
module lcm_board_model
  import lcm_pkg::*;
(
  output lcm_pins_t pins,
  input wire logic clk
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    pins = '0;
  end
  task automatic set(input lcm_pins_t v);
    @(posedge clk);
    pins <= v;
  endtask : set
  task automatic start_prog(input logic [LCM_PROG_W-1:0] num);
    lcm_pins_t v;
    v = pins;
    v.program_select = num;
    set(v);
    repeat (4) @(posedge clk);
    v.emission_request = 1'b1;
    set(v);
  endtask : start_prog
endmodule : lcm_board_model

/* verification/lcm_mode_ctrl_tb.sv */
// Self-checking testbench for the control-mode block.
module lcm_mode_ctrl_tb
  import lcm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic key = 1'b0;
  logic nv_valid = 1'b0;
  logic done = 1'b0;
  logic [15:0] nv_img = 16'h0001;
  logic [15:0] nv_data;
  logic nv_wr;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata;
  logic [7:0] pct;
  logic [6:0] prog;
  lcm_pins_t pins;
  lcm_pins_t p = '0;
  lcm_outs_t outs;
  int errors = 0;
  int cmp_count = 0;
  always #50 clk = ~clk;
  // stored image keeps the last saved settings across a reset.
  always @(posedge clk) begin
    if (nv_wr) begin
      nv_img <= nv_data;
    end
  end
  lcm_board_model brd (.pins(pins), .clk(clk));
  lcm_mode_ctrl #(.AIM_DELAY_CYC(4)) uut (.clk(clk), .rst_b(rst_b), .pin_strapped_key_position(key),
    .pins(pins), .program_done(done), .nv_cfg(nv_img), .nv_valid(nv_valid), .reg_addr(addr),
    .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .nv_save_data(nv_data), .nv_save(nv_wr),
    .outs(outs), .diode_current_pct(pct), .active_program(prog));
  task automatic give_verdict;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata & m, e);
  endtask : rd_reg
  // Waits on one output bit; index 7 is emission, 0 is main power.
  task automatic wt(input int i, input logic v);
    int n;
    n = 0;
    #1;
    while (outs[i] !== v && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk({15'h0, outs[i]}, {15'h0, v});
    // A wait that ran out has been counted as a mismatch by the compare above.
    if (outs[i] !== v) begin
      give_verdict();
    end
  endtask : wt
  task automatic t_local;
    @(posedge clk);
    nv_valid <= 1'b1;
    @(posedge clk);
    nv_valid <= 1'b0;
    rd_reg(LCM_REG_CFG, 16'hffff, 16'h0001);
    wt(6, 1'b1);
    wr_reg(LCM_REG_CFG, 16'h0000);
    wt(6, 1'b0);
    wr_reg(LCM_REG_PCT, 16'h0065);
    rd_reg(LCM_REG_PCT, 16'h00ff, 16'h0064);
    chk({8'h00, pct}, 16'h0064);
    wr_reg(LCM_REG_CMD, 16'h0080);
    rd_reg(LCM_REG_STAT, 16'h0080, 16'h0080);
    wr_reg(LCM_REG_CMD, 16'h0010);
    rd_reg(LCM_REG_STAT, 16'h0080, 16'h0000);
    wt(2, 1'b1);
    wr_reg(LCM_REG_CMD, 16'h0001);
    wt(7, 1'b1);
  endtask : t_local
  task automatic t_aim;
    wr_reg(LCM_REG_CMD, 16'h0004);
    #1;
    chk({15'h0, outs.aim_on}, 16'h0000);
    wt(3, 1'b1);
    chk({13'h0, outs.ready, outs.green_lamp, outs.emission_en}, 16'h0000);
    wr_reg(LCM_REG_CMD, 16'h0008);
    wt(1, 1'b1);
    wr_reg(LCM_REG_CMD, 16'h0001);
    wt(7, 1'b1);
    wr_reg(LCM_REG_CMD, 16'h0002);
    wt(7, 1'b0);
  endtask : t_aim
  task automatic t_prog;
    wr_reg(LCM_REG_CFG, 16'h0502);
    wt(5, 1'b1);
    chk(nv_data, 16'h0502);
    rd_reg(LCM_REG_NV, 16'hffff, 16'h0502);
    chk({9'h0, prog}, 16'h0005);
    p.gate_diff_pos = 1'b1;
    brd.set(p);
    wt(4, 1'b1);
    p.gate_diff_pos = 1'b0;
    brd.set(p);
    wt(4, 1'b0);
    rd_reg(LCM_REG_STAT, 16'h0040, 16'h0040);
    wr_reg(LCM_REG_CMD, 16'h0040);
    wr_reg(LCM_REG_CFG, 16'h0500);
    rd_reg(LCM_REG_STAT, 16'h0040, 16'h0000);
    wr_reg(LCM_REG_CMD, 16'h0001);
    wt(4, 1'b1);
    wr_reg(LCM_REG_CMD, 16'h0002);
    wt(4, 1'b0);
    wr_reg(LCM_REG_CFG, 16'h0502);
    p.gate_diff_pos = 1'b1;
    brd.set(p);
    wt(4, 1'b1);
    @(posedge clk);
    done <= 1'b1;
    wt(4, 1'b0);
    rd_reg(LCM_REG_STAT, 16'h0740, 16'h0400);
    p.gate_diff_pos = 1'b0;
    brd.set(p);
    done <= 1'b0;
    repeat (4) @(posedge clk);
    rd_reg(LCM_REG_STAT, 16'h0740, 16'h0100);
  endtask : t_prog
  // A second reset in mid-run must bring back the last saved local settings.
  task automatic t_nv;
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1;
    chk({8'h00, outs}, 16'h0000);
    @(posedge clk);
    nv_valid <= 1'b1;
    @(posedge clk);
    nv_valid <= 1'b0;
    rd_reg(LCM_REG_CFG, 16'hffff, 16'h0502);
  endtask : t_nv
  task automatic t_rem;
    @(posedge clk);
    key <= 1'b1;
    wr_reg(LCM_REG_CMD, 16'h0020);
    wt(0, 1'b0);
    wr_reg(LCM_REG_CFG, 16'h0001);
    rd_reg(LCM_REG_CFG, 16'hffff, 16'h0502);
    p.host_request = 1'b1;
    p.analog_select = 1'b1;
    p.main_power_request = 1'b1;
    brd.set(p);
    wt(0, 1'b1);
    wt(6, 1'b1);
    @(posedge clk);
    key <= 1'b0;
    wt(6, 1'b0);
    @(posedge clk);
    key <= 1'b1;
    p.analog_select = 1'b0;
    p.emission_request = 1'b1;
    p.gate_diff_pos = 1'b1;
    brd.set(p);
    wt(7, 1'b1);
    p.gate_diff_pos = 1'b0;
    brd.set(p);
    wt(7, 1'b0);
    p.emission_request = 1'b0;
    p.aiming_beam = 1'b1;
    brd.set(p);
    wt(3, 1'b1);
    p.aiming_beam = 1'b0;
    brd.set(p);
    wt(2, 1'b1);
    p.internal_select = 1'b1;
    brd.set(p);
    wr_reg(LCM_REG_CMD, 16'h0001);
    wt(7, 1'b1);
    wr_reg(LCM_REG_CMD, 16'h0002);
    wt(7, 1'b0);
    p.internal_select = 1'b0;
    brd.set(p);
    brd.start_prog(7'h09);
    wt(4, 1'b1);
    chk({9'h0, prog}, 16'h0009);
  endtask : t_rem
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1;
    chk({8'h00, outs}, 16'h0000);
    t_local();
    t_aim();
    t_prog();
    t_nv();
    t_rem();
    give_verdict();
  end
endmodule : lcm_mode_ctrl_tb
